// ==== dv/fail_lamp_model.sv ====
// Lamp or indicator load on one open-drain fail pin, with a pull-up.
// Assumes ext_low stands for an outside source pulling the wire low.
`timescale 1ns/10ps
`default_nettype none
module fail_lamp_model (
  // Pin drive from the block
  input  wire logic pin_out,
  input  wire logic pin_oe_n,
  // Outside source
  input  wire logic ext_low,
  // Wire level
  output logic      pad
);
  // Released wire goes to the pull-up level unless ext_low pulls it low
  assign pad = !pin_oe_n ? pin_out : !ext_low;
endmodule
`default_nettype wire

// ==== dv/fail_output_logic_tb.sv ====
// Self-checking bench for the fail output logic.
// Assumes shortened wave counts and lamp models on both alternate pins.
`timescale 1ns/10ps
`default_nettype none
module fail_output_logic_tb;
  import fail_out_pkg::*;
  localparam int BH = 8;
  localparam int PP = 80;
  logic       clk, rst, hot, shrt, ov, ov_en, force_on, bsw, dsw, wdis, bext, dext;
  logic [4:0] pls;
  logic [1:0] cfg, duty, wclr, wst, lvl;
  sbc_mode_t  mode;
  pin_func_t  bfunc, dfunc;
  logic       so, soe, bo, boe, dout, doe, fa, fl, wm, fsr, bpad, dpad;
  int         bad_count, n_compared, lb, ld, ls;
  int         pm[4] = '{200, 100, 50, 25};

  fail_output_logic #(.BLINK_HALF(BH), .PWM_PERIOD(PP)) fail_output_logic_i (
    .clk(clk), .rst(rst), .hot_shutdown(hot), .main_supply_short(shrt),
    .main_supply_ov(ov), .supply_ov_fault_enable(ov_en), .main_supply_uv_event(pls[0]),
    .main_supply_uv_reset(pls[1]), .wdog_fail_event(pls[2]), .wdog_trigger_ok(pls[3]),
    .wdog_disabled_in_stop(wdis), .hw_config(cfg), .mode(mode), .fail_out_force(force_on),
    .fault_latched_clear(pls[4]), .pwm_duty_select(duty), .blink_pin_func(bfunc),
    .dimmed_pin_func(dfunc), .blink_switch_on(bsw), .dimmed_switch_on(dsw),
    .wake_status_clear(wclr), .static_fail_out(so), .static_fail_oe_n(soe),
    .blink_fail_in(bpad), .blink_fail_out(bo), .blink_fail_oe_n(boe),
    .dimmed_fail_in(dpad), .dimmed_fail_out(dout), .dimmed_fail_oe_n(doe),
    .fail_active(fa), .fault_latched(fl), .wdog_miss_flag(wm), .fail_safe_request(fsr),
    .wake_event_status_two(wst), .pin_level_status(lvl));
  fail_lamp_model blink_lamp_i (.pin_out(bo), .pin_oe_n(boe), .ext_low(bext), .pad(bpad));
  fail_lamp_model dim_lamp_i (.pin_out(dout), .pin_oe_n(doe), .ext_low(dext), .pad(dpad));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input string what, input logic [9:0] seen, input logic [9:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic chk_on(input string what, input logic on);
    chk({what, " active"}, fa, on);
    chk({what, " static"}, soe, !on);
    chk({what, " blink"}, boe, !on);
    chk({what, " dimmed"}, doe, !on);
    chk({what, " static out"}, so, 1'b0);
  endtask
  task automatic pulse(input int i);
    @(posedge clk) pls[i] <= 1'b1;
    @(posedge clk) pls[i] <= 1'b0;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #(5000 * 100);
    bad_count++;
    wrap_up();
  end

  initial begin
    {hot, shrt, ov, ov_en, force_on, bsw, dsw, wdis, bext, dext} = '0;
    pls = '0; cfg = 2'h0; duty = 2'h0; wclr = 2'h0;
    mode = MODE_NORMAL; bfunc = PIN_FAIL; dfunc = PIN_FAIL;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("latched", fl, 1'b0);
    chk_on("reset", 1'b0);
    chk("level", lvl, 2'h3);
    $display("reset test done");
    for (int k = 0; k < 2; k++) begin
      @(posedge clk) if (k == 0) hot <= 1'b1; else shrt <= 1'b1;
      wait_cyc(1);
      chk_on("fault", 1'b1);
      chk("latched", fl, 1'b1);
      chk("safe req", fsr, 1'b1);
      pulse(4);
      wait_cyc(1);
      chk("latched", fl, 1'b1);
      @(posedge clk) {hot, shrt} <= 2'h0;
      wait_cyc(2);
      chk("held", fa, 1'b1);
      pulse(4);
      wait_cyc(2);
      chk_on("released", 1'b0);
    end
    @(posedge clk) ov <= 1'b1;
    wait_cyc(3);
    chk("ov off", fa, 1'b0);
    @(posedge clk) ov_en <= 1'b1;
    wait_cyc(1);
    chk_on("ov", 1'b1);
    @(posedge clk) {ov, ov_en} <= 2'h0;
    pulse(4);
    wait_cyc(2);
    chk_on("ov off", 1'b0);
    $display("fault test done");
    for (int k = 0; k < 2; k++) begin
      repeat (3) pulse(0);
      wait_cyc(3);
      chk("uv three", fa, 1'b0);
      if (k == 0) pulse(1);
    end
    pulse(0);
    wait_cyc(2);
    chk("uv four", fl, 1'b1);
    pulse(1);
    pulse(4);
    wait_cyc(2);
    chk_on("uv off", 1'b0);
    $display("undervoltage test done");
    @(posedge clk) force_on <= 1'b1;
    wait_cyc(1);
    chk_on("force", 1'b1);
    for (int d = 0; d < 4; d++) begin
      @(posedge clk) duty <= d[1:0];
      wait_cyc(PP);
      lb = 0; ld = 0; ls = 0;
      repeat (PP) begin
        @(negedge clk);
        lb += int'(boe === 1'b0);
        ld += int'(doe === 1'b0);
        ls += int'(soe === 1'b0);
      end
      chk("blink", 10'(lb), 10'(PP / 2));
      chk("pwm", 10'(ld), 10'(PP * pm[d] / 1000));
      chk("static", 10'(ls), 10'(PP));
    end
    chk("force latch", fl, 1'b0);
    @(posedge clk) force_on <= 1'b0;
    wait_cyc(2);
    chk_on("unforce", 1'b0);
    $display("waveform test done");
    pulse(2);
    wait_cyc(1);
    chk("miss", wm, 1'b1);
    chk("cfg1", fa, 1'b1);
    pulse(4);
    wait_cyc(2);
    chk("cfg1 hold", fa, 1'b1);
    pulse(3);
    pulse(4);
    wait_cyc(2);
    chk("miss clr", wm, 1'b0);
    chk_on("cfg1 off", 1'b0);
    @(posedge clk) cfg <= 2'h2;
    pulse(2);
    wait_cyc(2);
    chk("cfg3 one", fa, 1'b0);
    pulse(2);
    wait_cyc(1);
    chk("cfg3 two", fa, 1'b1);
    pulse(3);
    pulse(4);
    wait_cyc(2);
    @(posedge clk) cfg <= 2'h1;
    pulse(2);
    wait_cyc(1);
    chk("cfg2", fa, 1'b1);
    chk("cfg2 latch", fl, 1'b0);
    pulse(3);
    wait_cyc(2);
    chk_on("cfg2 off", 1'b0);
    $display("watchdog test done");
    @(posedge clk) begin
      bfunc <= PIN_WAKE;
      dfunc <= PIN_LOW_SIDE;
      dsw <= 1'b1;
    end
    wait_cyc(2);
    chk("wake drive", {boe, bo}, 2'h2);
    chk("ls drive", {doe, dout}, 2'h0);
    @(posedge clk) bext <= 1'b1;
    wait_cyc(5);
    chk("wake", wst, 2'h1);
    chk("level", lvl, 2'h0);
    @(posedge clk) begin
      bext <= 1'b0;
      dfunc <= PIN_HIGH_SIDE;
    end
    wait_cyc(5);
    chk("hs drive", {doe, dout}, 2'h1);
    chk("level hs", lvl, 2'h3);
    chk("wake held", wst, 2'h1);
    @(posedge clk) wclr <= 2'h1;
    @(posedge clk) wclr <= 2'h0;
    wait_cyc(1);
    chk("wake clr", wst, 2'h0);
    pulse(2);
    @(posedge clk) mode <= MODE_SLEEP;
    wait_cyc(2);
    chk("sleep miss", wm, 1'b0);
    chk("sleep hold", fa, 1'b1);
    chk("sleep hs", doe, 1'b1);
    pulse(2);
    wait_cyc(0);
    chk("sleep wd", wm, 1'b1);
    @(posedge clk) begin
      mode <= MODE_STOP;
      wdis <= 1'b1;
    end
    wait_cyc(2);
    chk("stop miss", wm, 1'b0);
    chk("stop hs", {doe, dout, fa}, 3'h3);
    @(posedge clk) begin
      mode <= MODE_NORMAL;
      wdis <= 1'b0;
    end
    wait_cyc(2);
    chk("stop off", fa, 1'b0);
    @(posedge clk) begin
      mode <= MODE_FAILSAFE;
      bfunc <= PIN_FAIL;
      dfunc <= PIN_FAIL;
    end
    wait_cyc(2);
    chk_on("failsafe", 1'b1);
    $display("pin test done");
    wrap_up();
  end
endmodule
`default_nettype wire

// ==== inc/fail_out_pkg.sv ====
// Constants, types and helpers for the fail output logic.
// Assumes a 10 MHz core clock shared by all users of this package.
package fail_out_pkg;

  // Core clock rate and waveform timing
  localparam longint CLK_HZ             = 10_000_000;
  localparam longint BLINK_FREQ_MILLIHZ = 1250;
  localparam longint PWM_FREQ_HZ        = 100;
  localparam int     BLINK_HALF_CYCLES  = int'(CLK_HZ * 1000 / (2 * BLINK_FREQ_MILLIHZ));
  localparam int     PWM_PERIOD_CYCLES  = int'(CLK_HZ / PWM_FREQ_HZ);

  // On-time in tenths of a percent, by duty select code
  localparam logic [9:0] DUTY_PERMILLE_0 = 10'h0C8;
  localparam logic [9:0] DUTY_PERMILLE_1 = 10'h064;
  localparam logic [9:0] DUTY_PERMILLE_2 = 10'h032;
  localparam logic [9:0] DUTY_PERMILLE_3 = 10'h019;
  localparam logic [1:0] DUTY_SEL_RESET  = 2'h0;

  // Fault counting
  localparam logic [2:0] UV_FAULT_COUNT = 3'h4;
  localparam logic [1:0] WD_THRESH_LOW  = 2'h1;
  localparam logic [1:0] WD_THRESH_HIGH = 2'h2;
  localparam logic [1:0] CFG_TWO        = 2'h1;
  localparam logic [3:0] WD_FAILSAFE_CFG_MASK = 4'h5;

  // Values after reset
  localparam logic       FLAG_RESET  = 1'b0;
  localparam logic [2:0] UV_RESET    = 3'h0;
  localparam logic [1:0] WD_RESET    = 2'h0;
  localparam logic [1:0] LEVEL_RESET = 2'h3;

  typedef enum logic [1:0] {MODE_NORMAL, MODE_STOP, MODE_SLEEP, MODE_FAILSAFE} sbc_mode_t;
  typedef enum logic [1:0] {PIN_FAIL, PIN_WAKE, PIN_LOW_SIDE, PIN_HIGH_SIDE} pin_func_t;

  function automatic logic [9:0] duty_permille(input logic [1:0] sel);
    case (sel)
      2'h0:    duty_permille = DUTY_PERMILLE_0;
      2'h1:    duty_permille = DUTY_PERMILLE_1;
      2'h2:    duty_permille = DUTY_PERMILLE_2;
      default: duty_permille = DUTY_PERMILLE_3;
    endcase
  endfunction

endpackage

// ==== rtl/alt_pin_ctrl.sv ====
// Driver and input path of one reconfigurable fail pin.
// Assumes pin_in is asynchronous and the pad resolves out and oe_n.
`timescale 1ns/10ps
`default_nettype none
module alt_pin_ctrl (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // Configuration
  input  wire fail_out_pkg::pin_func_t func,
  input  wire fail_out_pkg::sbc_mode_t mode,
  input  wire logic                    switch_on,
  input  wire logic                    fail_drive,
  // Pad
  input  wire logic                    pin_in,
  output logic                         pin_out,
  output logic                         pin_oe_n,
  // Observed pin
  output logic                         wake_event,
  output logic                         level
);
  import fail_out_pkg::*;

  logic sync1;
  logic prev;
  logic next_out;
  logic next_oe_n;
  logic next_wake;
  logic sw_allowed;

  always_comb begin
    sw_allowed = (mode == MODE_NORMAL) || (mode == MODE_STOP); // RQ23
    next_out = 1'b0;
    next_oe_n = 1'b1;
    next_wake = 1'b0;
    case (func) // RQ18
      PIN_FAIL: begin
        next_oe_n = !fail_drive; // RQ1
      end
      PIN_WAKE: begin
        next_wake = (mode != MODE_FAILSAFE) && (level != prev); // RQ19 RQ23
      end
      // Switches carry only their own current limit, no status
      PIN_LOW_SIDE: begin
        next_oe_n = !(switch_on && sw_allowed); // RQ20
      end
      PIN_HIGH_SIDE: begin
        next_out = 1'b1;
        next_oe_n = !(switch_on && sw_allowed); // RQ20
      end
      default: begin
        next_oe_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1 <= 1'b1;
      level <= 1'b1;
      prev <= 1'b1;
      pin_out <= 1'b0;
      pin_oe_n <= 1'b1;
      wake_event <= FLAG_RESET;
    end else begin
      sync1 <= pin_in;
      level <= sync1;
      prev <= level;
      pin_out <= next_out;
      pin_oe_n <= next_oe_n;
      wake_event <= next_wake;
    end
  end

endmodule
`default_nettype wire

// ==== rtl/fail_output_logic.sv ====
// Failure collection and fail pin control of the supply basis chip.
// Assumes fault inputs come from logic on clk and pins are asynchronous.
//
// Notes on behaviour
// RQ1: Three open-drain fail pins pull low while a failure is active.
// RQ2: Thermal shutdown or main supply short activates the fail outputs.
// RQ3: Watchdog miss activates on first miss in configs 1-2, second in 3-4.
// RQ4: Main supply overvoltage counts only while its fault enable is set.
// RQ5: Four consecutive main supply undervoltage events activate the outputs.
// RQ6: Fail-safe is requested with activation; watchdog cases depend on config.
// RQ7: Every failure activation except the first watchdog miss in config 2 sets the fault-latched status bit.
// RQ8: The force bit activates the outputs regardless of failure status.
// RQ9: Clearing force with no failure turns outputs off, no trigger needed.
// RQ10: Normal mode release needs faults gone and the latched bit cleared.
// RQ11: After a watchdog fault a good trigger must also clear the miss flag.
// RQ12: Miss flag clears on sleep, non-watchdog fail-safe, or stop with wdog off.
// RQ13: In config 2 the first watchdog miss does not set the latched bit.
// RQ14: All fail outputs start together; the first one is held low.
// RQ15: The second output blinks at 1.25 Hz with half duty while active.
// RQ16: The third output is a 100 Hz PWM, default on-time one fifth.
// RQ17: PWM duty is selectable among 20, 10, 5 and 2.5 percent.
// RQ18: Pins two and three default to fail use, reassignable by control.
// RQ19: A pin used as wake input records its events in wake status two.
// RQ20: Switch configurations report no diagnosis besides current limiting.
// RQ21: Normal and stop modes mirror live pin levels into level status.
// RQ22: The second alternate pin level shares the test pin level bit.
// RQ23: Per-mode pin behaviour: hold, fail-safe active, wake and switch limits.
// RQ24: Blink and PWM counters run on clk and restart at activation.
`timescale 1ns/10ps
`default_nettype none
module fail_output_logic #(
  parameter int BLINK_HALF = fail_out_pkg::BLINK_HALF_CYCLES,
  parameter int PWM_PERIOD = fail_out_pkg::PWM_PERIOD_CYCLES
) (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // Fault sources
  input  wire logic                    hot_shutdown,
  input  wire logic                    main_supply_short,
  input  wire logic                    main_supply_ov,
  input  wire logic                    supply_ov_fault_enable,
  input  wire logic                    main_supply_uv_event,
  input  wire logic                    main_supply_uv_reset,
  // Watchdog
  input  wire logic                    wdog_fail_event,
  input  wire logic                    wdog_trigger_ok,
  input  wire logic                    wdog_disabled_in_stop,
  // Configuration and mode
  input  wire logic [1:0]              hw_config,
  input  wire fail_out_pkg::sbc_mode_t mode,
  // Serial control bits
  input  wire logic                    fail_out_force,
  input  wire logic                    fault_latched_clear,
  input  wire logic [1:0]              pwm_duty_select,
  input  wire fail_out_pkg::pin_func_t blink_pin_func,
  input  wire fail_out_pkg::pin_func_t dimmed_pin_func,
  input  wire logic                    blink_switch_on,
  input  wire logic                    dimmed_switch_on,
  input  wire logic [1:0]              wake_status_clear,
  // Pins
  output logic                         static_fail_out,
  output logic                         static_fail_oe_n,
  input  wire logic                    blink_fail_in,
  output logic                         blink_fail_out,
  output logic                         blink_fail_oe_n,
  input  wire logic                    dimmed_fail_in,
  output logic                         dimmed_fail_out,
  output logic                         dimmed_fail_oe_n,
  // Status
  output logic                         fail_active,
  output logic                         fault_latched,
  output logic                         wdog_miss_flag,
  output logic                         fail_safe_request,
  output logic [1:0]                   wake_event_status_two,
  output logic [1:0]                   pin_level_status
);
  import fail_out_pkg::*;

  sbc_mode_t   mode_prev;
  logic [2:0]  uv_count;
  logic [1:0]  wd_count;
  logic [2:0]  next_uv_count;
  logic [1:0]  next_wd_count;
  logic        next_miss;
  logic        next_latched;
  logic        next_active;
  logic        next_fs_request;
  logic [1:0]  next_wake_status;
  logic [1:0]  next_level_status;
  logic        fault_present;
  logic [1:0]  wd_thresh;
  logic        wd_reached;
  logic        latch_wd;
  logic        latch_set;
  logic        enter_sleep;
  logic        enter_fs;
  logic        miss_clear;
  logic        blink_wave;
  logic        pwm_wave;
  logic [1:0]  wake_event;
  logic [1:0]  pin_level;

  // Fault and watchdog evaluation
  always_comb begin
    fault_present = hot_shutdown || main_supply_short // RQ2
                    || (main_supply_ov && supply_ov_fault_enable) // RQ4
                    || (uv_count == UV_FAULT_COUNT); // RQ5
    wd_thresh = hw_config[1] ? WD_THRESH_HIGH : WD_THRESH_LOW; // RQ3
    wd_reached = wdog_miss_flag && (wd_count >= wd_thresh); // RQ3
    latch_wd = wd_reached && !((hw_config == CFG_TWO) && (wd_count == 2'h1)); // RQ13
    latch_set = fault_present || latch_wd; // RQ7
    enter_sleep = (mode == MODE_SLEEP) && (mode_prev != MODE_SLEEP);
    enter_fs = (mode == MODE_FAILSAFE) && (mode_prev != MODE_FAILSAFE);
    miss_clear = wdog_trigger_ok || enter_sleep // RQ11 RQ12
                 || (enter_fs && fault_present)
                 || ((mode == MODE_STOP) && wdog_disabled_in_stop); // RQ12
  end

  // Counters and sticky flags; a set always beats a clear
  always_comb begin
    next_uv_count = uv_count;
    if (main_supply_uv_event) begin
      if (uv_count != UV_FAULT_COUNT) begin
        next_uv_count = uv_count + 3'h1; // RQ5
      end
    end else if (main_supply_uv_reset) begin
      next_uv_count = UV_RESET;
    end
    next_wd_count = wd_count;
    next_miss = wdog_miss_flag;
    if (wdog_fail_event) begin
      next_miss = 1'b1;
      if (wd_count != 2'h3) begin
        next_wd_count = wd_count + 2'h1;
      end
    end else if (miss_clear) begin
      next_miss = 1'b0; // RQ12
      next_wd_count = WD_RESET;
    end
    next_latched = fault_latched;
    if (latch_set) begin
      next_latched = 1'b1; // RQ7
    end else if (fault_latched_clear) begin
      next_latched = 1'b0; // RQ10
    end
  end

  // Fail output state per mode
  always_comb begin
    case (mode)
      MODE_FAILSAFE: begin
        next_active = 1'b1; // RQ23
      end
      MODE_STOP, MODE_SLEEP: begin
        next_active = fail_active; // RQ23
      end
      MODE_NORMAL: begin
        next_active = fail_out_force // RQ8 RQ9
                      || fault_present || fault_latched // RQ10
                      || wd_reached; // RQ11
      end
      default: begin
        next_active = fail_active;
      end
    endcase
    next_fs_request = fault_present // RQ6
                      || (wd_reached && WD_FAILSAFE_CFG_MASK[hw_config]); // RQ6
  end

  // Wake and level status
  always_comb begin
    next_wake_status = (wake_event_status_two & ~wake_status_clear) | wake_event; // RQ19
    next_level_status = pin_level_status;
    if ((mode == MODE_NORMAL) || (mode == MODE_STOP)) begin
      next_level_status = pin_level; // RQ21 RQ22
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_prev <= MODE_NORMAL;
      uv_count <= UV_RESET;
      wd_count <= WD_RESET;
      wdog_miss_flag <= FLAG_RESET;
      fault_latched <= FLAG_RESET;
      fail_active <= FLAG_RESET;
      fail_safe_request <= FLAG_RESET;
      static_fail_out <= 1'b0;
      static_fail_oe_n <= 1'b1;
      wake_event_status_two <= 2'h0;
      pin_level_status <= LEVEL_RESET;
    end else begin
      mode_prev <= mode;
      uv_count <= next_uv_count;
      wd_count <= next_wd_count;
      wdog_miss_flag <= next_miss;
      fault_latched <= next_latched;
      fail_active <= next_active;
      fail_safe_request <= next_fs_request;
      static_fail_out <= 1'b0;
      static_fail_oe_n <= !next_active; // RQ1 RQ14
      wake_event_status_two <= next_wake_status;
      pin_level_status <= next_level_status;
    end
  end

  // Waves follow the next fail state so all pins switch together
  fail_wave_gen #(
    .BLINK_HALF (BLINK_HALF),
    .PWM_PERIOD (PWM_PERIOD)
  ) u_wave (
    .clk      (clk),
    .rst      (rst),
    .active   (next_active), // RQ14 RQ24
    .duty_sel (pwm_duty_select),
    .blink_on (blink_wave),
    .pwm_on   (pwm_wave)
  );

  alt_pin_ctrl u_blink_pin (
    .clk        (clk),
    .rst        (rst),
    .func       (blink_pin_func),
    .mode       (mode),
    .switch_on  (blink_switch_on),
    .fail_drive (blink_wave), // RQ15
    .pin_in     (blink_fail_in),
    .pin_out    (blink_fail_out),
    .pin_oe_n   (blink_fail_oe_n),
    .wake_event (wake_event[0]),
    .level      (pin_level[0])
  );

  // Pin three doubles as the test pin; its level bit is shared
  alt_pin_ctrl u_dimmed_pin (
    .clk        (clk),
    .rst        (rst),
    .func       (dimmed_pin_func),
    .mode       (mode),
    .switch_on  (dimmed_switch_on),
    .fail_drive (pwm_wave), // RQ16
    .pin_in     (dimmed_fail_in),
    .pin_out    (dimmed_fail_out),
    .pin_oe_n   (dimmed_fail_oe_n),
    .wake_event (wake_event[1]),
    .level      (pin_level[1]) // RQ22
  );

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence wd_first_miss_s;
    wdog_fail_event && !hw_config[1] && (mode == MODE_NORMAL);
  endsequence

  sequence stay_normal_s;
    mode == MODE_NORMAL;
  endsequence

  sequence cfg2_first_s;
    wdog_fail_event && (hw_config == CFG_TWO) && (wd_count == 2'h0)
    && !wdog_miss_flag && !fault_present && !fault_latched;
  endsequence

  sequence quiet_s;
    !fault_present && !wdog_fail_event && (hw_config == CFG_TWO);
  endsequence

  sequence uv_fourth_s;
    main_supply_uv_event && (uv_count == 3'h3);
  endsequence

  static_low_a: assert property ( // RQ14
    fail_active |-> (!static_fail_oe_n && !static_fail_out))
    else $error("static fail pin not pulled low while active");

  hot_fault_a: assert property ( // RQ2
    (hot_shutdown && (mode == MODE_NORMAL)) |=> fail_active)
    else $error("thermal fault did not activate fail outputs");

  latch_set_a: assert property ( // RQ7
    fault_present |=> fault_latched)
    else $error("fault latched bit not set");

  ov_gate_a: assert property ( // RQ4
    (main_supply_ov && !supply_ov_fault_enable && !hot_shutdown
     && !main_supply_short && (uv_count != UV_FAULT_COUNT)) |-> !fault_present)
    else $error("overvoltage counted while disabled");

  uv_fourth_a: assert property ( // RQ5
    uv_fourth_s |=> ##1 fault_latched)
    else $error("fourth undervoltage did not latch a fault");

  wd_first_a: assert property ( // RQ3
    wd_first_miss_s ##1 stay_normal_s |=> fail_active)
    else $error("first watchdog miss did not activate in config 1 or 2");

  cfg2_nolatch_a: assert property ( // RQ13
    cfg2_first_s ##1 quiet_s |=> !fault_latched)
    else $error("config 2 first watchdog miss set fault latched");

  force_on_a: assert property ( // RQ8
    (fail_out_force && (mode == MODE_NORMAL)) |=> fail_active)
    else $error("force bit did not activate fail outputs");

  release_a: assert property ( // RQ9
    (!fail_out_force && !fault_present && !fault_latched && !wd_reached
     && (mode == MODE_NORMAL)) |=> !fail_active)
    else $error("fail outputs not released with no failure");

  hold_latch_a: assert property ( // RQ10
    (fault_latched && (mode == MODE_NORMAL)) |=> fail_active)
    else $error("fail outputs released while fault latched");

  miss_clear_a: assert property ( // RQ11
    (wdog_trigger_ok && !wdog_fail_event) |=> !wdog_miss_flag)
    else $error("good trigger did not clear watchdog miss");

  sleep_clear_a: assert property ( // RQ12
    (enter_sleep && !wdog_fail_event) |=> !wdog_miss_flag)
    else $error("sleep entry did not clear watchdog miss");

  failsafe_req_a: assert property ( // RQ6
    fault_present |=> fail_safe_request)
    else $error("fail-safe not requested for a fault");

  failsafe_on_a: assert property ( // RQ23
    (mode == MODE_FAILSAFE) |=> (fail_active && !static_fail_oe_n))
    else $error("fail outputs inactive in fail-safe mode");

  blink_start_a: assert property ( // RQ15
    ($rose(fail_active) && ($past(blink_pin_func) == PIN_FAIL)) |-> !blink_fail_oe_n)
    else $error("blink pin did not start with the fail state");

  switch_sleep_a: assert property ( // RQ23
    ((mode == MODE_SLEEP) && (dimmed_pin_func != PIN_FAIL)) |=> dimmed_fail_oe_n)
    else $error("reconfigured pin drives in sleep mode");

  wake_sticky_a: assert property ( // RQ19
    (wake_event[0] && !wake_status_clear[0]) ##1 !wake_status_clear[0]
    |-> wake_event_status_two[0] [*2])
    else $error("wake event not held in wake status");

  level_mirror_a: assert property ( // RQ21
    (mode == MODE_NORMAL) |=> (pin_level_status == $past(pin_level)))
    else $error("pin level status does not follow the pins");

endmodule
`default_nettype wire

// ==== rtl/fail_wave_gen.sv ====
// Blink and dimming waveform counters for the fail outputs.
// Assumes active is the next value of the fail state, so waves align.
`timescale 1ns/10ps
`default_nettype none
module fail_wave_gen #(
  parameter int BLINK_HALF = fail_out_pkg::BLINK_HALF_CYCLES,
  parameter int PWM_PERIOD = fail_out_pkg::PWM_PERIOD_CYCLES
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Control
  input  wire logic       active,
  input  wire logic [1:0] duty_sel,
  // Waveforms, valid for the coming cycle
  output logic            blink_on,
  output logic            pwm_on
);
  import fail_out_pkg::*;

  logic        active_d;
  logic        phase;
  logic [22:0] blink_cnt;
  logic [16:0] pwm_cnt;
  logic        next_phase;
  logic [22:0] next_blink_cnt;
  logic [16:0] next_pwm_cnt;
  logic [16:0] on_cycles;

  always_comb begin
    on_cycles = 17'((PWM_PERIOD * int'(duty_permille(duty_sel))) / 1000); // RQ16 RQ17
    next_phase = phase;
    next_blink_cnt = blink_cnt;
    next_pwm_cnt = pwm_cnt;
    if (active && !active_d) begin // RQ24
      next_phase = 1'b1;
      next_blink_cnt = 23'h000000;
      next_pwm_cnt = 17'h00000;
    end else if (active) begin
      if (blink_cnt == 23'(BLINK_HALF - 1)) begin // RQ15
        next_blink_cnt = 23'h000000;
        next_phase = !phase;
      end else begin
        next_blink_cnt = blink_cnt + 23'h000001;
      end
      if (pwm_cnt == 17'(PWM_PERIOD - 1)) begin
        next_pwm_cnt = 17'h00000;
      end else begin
        next_pwm_cnt = pwm_cnt + 17'h00001;
      end
    end
    blink_on = active && next_phase;
    pwm_on = active && (next_pwm_cnt < on_cycles); // RQ16
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      active_d <= FLAG_RESET;
      phase <= FLAG_RESET;
      blink_cnt <= 23'h000000;
      pwm_cnt <= 17'h00000;
    end else begin
      active_d <= active;
      phase <= next_phase;
      blink_cnt <= next_blink_cnt;
      pwm_cnt <= next_pwm_cnt;
    end
  end

endmodule
`default_nettype wire
